// *** verilog/slp_codec.sv ***
// switch-logic payload codec: packet former, packet acceptor and switch outputs
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Function
// - state byte then four serial number bytes
// - bits 6..4 carry inputs 3..1
// - tag beacon sets bits 0 and 4
// - network serial node drops unlearned senders
// - forwarded serial number equals header number
// - zero state byte clears outputs at once
// - outputs 3..1 follow state bits 6..4
// - outside network mode accept every packet
// - network single byte needs learned sender
// - five-byte payload needs own serial match
// - learning stores header serial number only
// - hold outputs 500 ms or 20 ms
// - no state packet while all inputs low
// - resend every 15 ms while any high
module slp_codec #(
  parameter int TICK_CYCLES = slp_pkg::TICK_CYC,
  parameter int LEARN_DEPTH = 4,
  parameter int BEACON_PERIOD_MS = slp_pkg::BEACON_MS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire slp_pkg::slp_bus_req_t i_bus,
  output logic [31:0] o_rdata,
  input wire logic [2:0] i_logic_in,
  input wire logic i_hang_sel,
  input wire logic i_learn,
  input wire logic i_rx_valid,
  input wire slp_pkg::slp_byte_t i_rx,
  input wire logic [31:0] i_rx_hdr_sn,
  output slp_pkg::slp_byte_t o_tx,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic o_switch_output_first,
  output logic o_switch_output_second,
  output logic o_switch_output_third,
  output logic o_learning
);
  import slp_pkg::*;

  localparam int LW = (LEARN_DEPTH > 1) ? $clog2(LEARN_DEPTH) : 1;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] tick_cnt; // millisecond divider
    logic tick; // one-cycle millisecond enable
    logic [2:0] ctrl; // network, serial role, tag
    logic [31:0] own_sn; // own unit serial number
    logic [31:0] rdata; // read answer, one cycle
    slp_tx_st_t tx_st; // packet sender state
    logic [2:0] tx_idx; // byte index within packet
    logic [39:0] tx_data; // packet being sent, msb first
    logic [2:0] prev_in; // inputs at last look
    logic tx_pend; // state packet due
    logic bcn_pend; // beacon packet due
    logic fwd_pend; // received packet to forward
    logic [39:0] fwd_data; // forwarded state byte and header number
    logic [11:0] resend_ms; // time since last state packet
    logic [11:0] beacon_ms; // time since last beacon
    logic [11:0] hang_ms; // hang time left
    logic hang_on; // outputs held by hang timer
    logic [2:0] outs; // switch outputs 3..1
    logic [2:0] rx_cnt; // bytes seen in current packet
    logic [7:0] rx_state; // first byte of packet
    logic [31:0] rx_sn; // payload serial number
    logic [LEARN_DEPTH-1:0][31:0] learned; // learned sender numbers
    logic [LEARN_DEPTH-1:0] learn_vld; // slot holds a number
    logic [LW-1:0] learn_ptr; // next slot to fill
    logic [7:0] acc_cnt; // accepted packets, wraps
    logic learn_q; // learn state seen through one more flop
  } slp_st_t;

  slp_st_t s;
  slp_st_t next_s;
  logic [2:0] in_now; // synchronised logic inputs
  logic hang_sel; // synchronised hang-time select
  logic learning; // synchronised learn request
  logic buf_ready; // buffer can take a byte
  logic buf_valid; // sender offers a byte
  slp_byte_t buf_in; // byte offered to the buffer

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  slp_sync3 #(.W(5)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pin({i_logic_in, i_hang_sel, i_learn}),
    .o_level({in_now, hang_sel, learning})
  );

  // sender offers the top byte while sending
  always_comb begin
    buf_valid = (s.tx_st == SLP_TX_SEND);
    buf_in.data = s.tx_data[39:32];
    buf_in.last = (s.tx_idx == 3'(PAY_LONG - 1));
  end

  // ----------------------------------------
  // output buffer, stalls the sender when full
  // ----------------------------------------
  slp_buf2 #(.W($bits(slp_byte_t))) u_buf (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(buf_valid),
    .i_in_data(buf_in),
    .o_in_ready(buf_ready),
    .o_out_valid(o_tx_valid),
    .o_out_data(o_tx),
    .i_out_ready(i_tx_ready)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic hit; // header number is learned
    logic acc; // packet accepted by receiver
    logic [2:0] len; // payload length, saturating
    logic [7:0] sb; // state byte of packet
    logic [31:0] psn; // payload serial number
    logic [31:0] r; // read word
    hit = 1'b0;
    acc = 1'b0;
    len = 3'd0;
    sb = 8'h00;
    psn = 32'h0;
    r = 32'h0;
    next_s = s;

    // millisecond enable
    next_s.tick = 1'b0;
    if (s.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = 32'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 32'h1;
    end

    // register reads answer in the next cycle only
    next_s.rdata = 32'h0;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        REG_CTRL: r[2:0] = s.ctrl;
        REG_OWN_SN: r = s.own_sn;
        REG_STATUS: begin
          r[STAT_OUT_LSB +: 3] = s.outs;
          r[STAT_LEARN_BIT] = learning;
          r[STAT_ACC_LSB +: 8] = s.acc_cnt;
        end
        default: r = 32'h0; // unmapped reads as zero
      endcase
      next_s.rdata = r;
    end
    // register writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        REG_CTRL: next_s.ctrl = i_bus.wdata[2:0];
        REG_OWN_SN: next_s.own_sn = i_bus.wdata;
        REG_FLUSH: next_s.learn_vld = '0;
        default: ; // unmapped writes dropped
      endcase
    end

    // hang timer runs out, outputs drop
    if (s.tick && s.hang_on) begin
      if (s.hang_ms <= 12'd1) begin
        next_s.outs = 3'b000;
        next_s.hang_on = 1'b0;
      end else begin
        next_s.hang_ms = s.hang_ms - 12'd1;
      end
    end

    // ------------------------------------
    // receive path
    // ------------------------------------
    for (int i = 0; i < LEARN_DEPTH; i++) begin
      if (s.learn_vld[i] && (s.learned[i] == i_rx_hdr_sn)) begin
        hit = 1'b1;
      end
    end
    sb = (s.rx_cnt == 3'd0) ? i_rx.data : s.rx_state;
    psn = (s.rx_cnt == 3'd4) ? {s.rx_sn[23:0], i_rx.data} : s.rx_sn;
    len = (s.rx_cnt == 3'd6) ? 3'd6 : s.rx_cnt + 3'd1;
    if (i_rx_valid) begin
      // collect state byte and payload serial number
      if (s.rx_cnt == 3'd0) begin
        next_s.rx_state = i_rx.data;
      end else if (s.rx_cnt <= 3'd4) begin
        next_s.rx_sn = {s.rx_sn[23:0], i_rx.data};
      end
      next_s.rx_cnt = len;
      if (i_rx.last) begin
        next_s.rx_cnt = 3'd0;
        if (!s.ctrl[CTRL_NET_BIT]) begin
          acc = 1'b1;
        end else if (len == 3'(PAY_LONG)) begin
          acc = (psn == s.own_sn);
        end else if (len == 3'(PAY_SHORT)) begin
          acc = hit;
        end
        if (s.ctrl[CTRL_SER_BIT]) begin
          // serial node forwards state byte with header number
          if (!s.ctrl[CTRL_NET_BIT] || hit) begin
            next_s.fwd_pend = 1'b1;
            next_s.fwd_data = {sb, i_rx_hdr_sn};
          end
        end else if (acc) begin
          next_s.acc_cnt = s.acc_cnt + 8'd1;
          if (sb == 8'h00) begin
            next_s.outs = 3'b000;
            next_s.hang_on = 1'b0;
          end else begin
            next_s.outs = sb[ST_IN_HI:ST_IN_LO];
            next_s.hang_on = 1'b1;
            next_s.hang_ms = hang_sel ? 12'(HANG_SHORT_MS) : 12'(HANG_LONG_MS);
          end
        end
        // learning keeps only the header number
        if (learning && !hit) begin
          next_s.learned[s.learn_ptr] = i_rx_hdr_sn;
          next_s.learn_vld[s.learn_ptr] = 1'b1;
          next_s.learn_ptr = (s.learn_ptr == LW'(LEARN_DEPTH - 1)) ? '0 : s.learn_ptr + 1'b1;
        end
      end
    end

    // ------------------------------------
    // transmit triggers
    // ------------------------------------
    next_s.prev_in = in_now;
    next_s.learn_q = learning; // learn flag for the output pin
    if (s.tick) begin
      next_s.resend_ms = s.resend_ms + 12'd1;
      next_s.beacon_ms = s.beacon_ms + 12'd1;
    end
    if (s.ctrl[CTRL_SER_BIT] || (in_now == 3'b000)) begin
      next_s.resend_ms = 12'd0;
      next_s.tx_pend = 1'b0;
    end else if ((in_now != s.prev_in) ||
                 (s.tick && (s.resend_ms >= 12'(RESEND_MS - 1)))) begin
      next_s.tx_pend = 1'b1;
      next_s.resend_ms = 12'd0;
    end
    if (!s.ctrl[CTRL_TAG_BIT] || s.ctrl[CTRL_SER_BIT]) begin
      next_s.beacon_ms = 12'd0;
      next_s.bcn_pend = 1'b0;
    end else if (s.tick && (s.beacon_ms >= 12'(BEACON_PERIOD_MS - 1))) begin
      next_s.bcn_pend = 1'b1;
      next_s.beacon_ms = 12'd0;
    end

    // ------------------------------------
    // packet sender
    // ------------------------------------
    unique case (s.tx_st)
      SLP_TX_IDLE: begin
        next_s.tx_idx = 3'd0;
        if (s.fwd_pend) begin
          next_s.tx_data = s.fwd_data;
          next_s.fwd_pend = next_s.fwd_pend && (s.fwd_data != next_s.fwd_data);
          next_s.tx_st = SLP_TX_SEND;
        end else if (s.bcn_pend) begin
          // beacon marks bit 0 and bit 4
          next_s.tx_data = {1'b0, in_now[2:1], 1'b1, 3'b000, 1'b1, s.own_sn};
          next_s.bcn_pend = 1'b0;
          next_s.tx_st = SLP_TX_SEND;
        end else if (s.tx_pend) begin
          // state byte with spare bits zero, then own number
          next_s.tx_data = {1'b0, in_now, 4'b0000, s.own_sn};
          next_s.tx_pend = 1'b0;
          next_s.tx_st = SLP_TX_SEND;
        end
      end
      SLP_TX_SEND: begin
        if (buf_ready) begin
          next_s.tx_data = {s.tx_data[31:0], 8'h00};
          next_s.tx_idx = s.tx_idx + 3'd1;
          if (s.tx_idx == 3'(PAY_LONG - 1)) begin
            next_s.tx_st = SLP_TX_IDLE;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.own_sn <= OWN_SN_RST;
      s.tx_st <= SLP_TX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_rdata = s.rdata;
  assign o_switch_output_first = s.outs[0];
  assign o_switch_output_second = s.outs[1];
  assign o_switch_output_third = s.outs[2];
  assign o_learning = s.learn_q;

endmodule // slp_codec

// *** verilog/slp_pkg.sv ***
// shared constants and types of the switch-logic payload codec
package slp_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200; // system clock rate
  localparam int TICK_US = 1000; // millisecond tick period in us
  localparam int TICK_CYC = TICK_US * CLK_MHZ; // cycles per millisecond tick
  localparam int HANG_LONG_MS = 500; // hang time, select low
  localparam int HANG_SHORT_MS = 20; // hang time, select high
  localparam int RESEND_MS = 15; // resend period while any input high
  localparam int BEACON_MS = 2000; // tag beacon period

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // mode control
  localparam logic [7:0] REG_OWN_SN = 8'h04; // own unit serial number
  localparam logic [7:0] REG_STATUS = 8'h08; // outputs, learn flag, accept count
  localparam logic [7:0] REG_FLUSH = 8'h0c; // write: forget learned numbers
  localparam int CTRL_NET_BIT = 0; // network mode
  localparam int CTRL_SER_BIT = 1; // serial-mode node role
  localparam int CTRL_TAG_BIT = 2; // tag transmitter, periodic beacon
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [31:0] OWN_SN_RST = 32'h0;
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_LEARN_BIT = 4;
  localparam int STAT_ACC_LSB = 8;

  // ----------------------------------------
  // payload layout
  // ----------------------------------------
  localparam int ST_IN_HI = 6; // input 3 / output 3
  localparam int ST_IN_LO = 4; // input 1 / output 1
  localparam int ST_BEACON_BIT = 0; // periodic beacon marker
  localparam int PAY_SHORT = 1; // state byte only
  localparam int PAY_LONG = 5; // state byte plus serial number

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } slp_bus_req_t;

  // one payload byte with end-of-packet flag
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } slp_byte_t;

  // packet sender states
  typedef enum logic [1:0] {
    SLP_TX_IDLE = 2'b01,
    SLP_TX_SEND = 2'b10
  } slp_tx_st_t;

endpackage

// *** verilog/slp_sync3.sv ***
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module slp_sync3 #(
  parameter int W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  import slp_pkg::*;

  // stages and the accepted level
  typedef struct packed {
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic [W-1:0] c;
    logic [W-1:0] q;
  } slp_sync_t;

  slp_sync_t s;
  slp_sync_t next_s;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.a = i_pin;
    next_s.b = s.a; // first stage feeds only the second
    next_s.c = s.b;
    if (s.b == s.c) begin
      next_s.q = s.c; // stable over two stages
    end
  end

  // registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.q;

endmodule // slp_sync3

// *** verilog/slp_buf2.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module slp_buf2 #(
  parameter int W = 9
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  import slp_pkg::*;

  // entries, fill level and registered handshake flags
  typedef struct packed {
    logic [1:0][W-1:0] e;
    logic [1:0] cnt;
    logic vld;
    logic rdy;
  } slp_buf_t;

  slp_buf_t s;
  slp_buf_t next_s;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] c;
    c = s.cnt;
    next_s = s;
    // pop the head and move the tail up
    if (s.vld && i_out_ready) begin
      next_s.e[0] = s.e[1];
      c = c - 2'd1;
    end
    // push into the first free slot
    if (i_in_valid && s.rdy) begin
      next_s.e[c[0]] = i_in_data;
      c = c + 2'd1;
    end
    next_s.cnt = c;
    next_s.vld = (c != 2'd0);
    next_s.rdy = (c != 2'd2); // full stalls the source
  end

  // registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{e: '0, cnt: 2'd0, vld: 1'b0, rdy: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign o_in_ready = s.rdy;
  assign o_out_valid = s.vld;
  assign o_out_data = s.e[0];

endmodule // slp_buf2

// *** verification/slp_codec_properties.sv ***
// concurrent checks on the payload codec ports
`timescale 1ns/1ps
module slp_codec_properties
  import slp_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire slp_pkg::slp_bus_req_t i_bus,
  input wire logic [31:0] o_rdata,
  input wire logic i_hang_sel,
  input wire logic i_rx_valid,
  input wire slp_pkg::slp_byte_t i_rx,
  input wire slp_pkg::slp_byte_t o_tx,
  input wire logic o_tx_valid,
  input wire logic i_tx_ready,
  input wire logic o_switch_output_first,
  input wire logic o_switch_output_second,
  input wire logic o_switch_output_third
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  localparam int HOLD_CYC = (HANG_SHORT_MS - 2) * TICK_CYCLES; // surely still held
  localparam int DROP_CYC = (HANG_SHORT_MS + 2) * TICK_CYCLES + 8; // surely dropped
  logic first_q; // next rx byte opens a packet
  logic net_q; // network mode as last written
  logic ser_q; // serial role as last written
  logic [2:0] tx_cnt; // bytes taken within the current packet
  logic [15:0] idle_cnt; // cycles since the last rx byte
  logic [2:0] outs; // outputs 3..1
  assign outs = {o_switch_output_third, o_switch_output_second, o_switch_output_first};

  // track packet framing, mode and idle time
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_q <= 1'b1;
      net_q <= 1'b0;
      ser_q <= 1'b0;
      tx_cnt <= 3'h0;
      idle_cnt <= 16'h0;
    end else begin
      if (i_rx_valid) first_q <= i_rx.last;
      if (i_bus.wr && i_bus.addr == REG_CTRL) begin
        net_q <= i_bus.wdata[CTRL_NET_BIT];
        ser_q <= i_bus.wdata[CTRL_SER_BIT];
      end
      if (o_tx_valid && i_tx_ready) tx_cnt <= (tx_cnt == 3'h4) ? 3'h0 : tx_cnt + 3'h1;
      if (i_rx_valid) idle_cnt <= 16'h0;
      else if (idle_cnt != 16'hffff) idle_cnt <= idle_cnt + 16'h1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  // a lone state byte taken by a receiver outside network mode
  // (a serial-role node only forwards and leaves its outputs alone)
  sequence s_short_pkt;
    i_rx_valid && i_rx.last && first_q && !net_q && !ser_q;
  endsequence

  out_follow_a: assert property (s_short_pkt |=> outs == $past(i_rx.data[6:4]))
    else $error("outputs do not follow state bits");
  zero_clear_a: assert property (s_short_pkt ##0 i_rx.data == 8'h00 |=> outs == 3'h0)
    else $error("zero state byte did not clear outputs");
  // refused packets restart the idle count but not the hang timer,
  // so the hold is judged only where every packet drives the outputs
  hang_hold_a: assert property (!net_q && !ser_q && idle_cnt > 2 && idle_cnt < HOLD_CYC
    |-> $stable(outs))
    else $error("outputs changed without new data");
  hang_drop_a: assert property (idle_cnt == DROP_CYC && i_hang_sel |-> outs == 3'h0)
    else $error("outputs held past short hang time");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx))
    else $error("offered byte dropped or changed");
  tx_last_a: assert property (o_tx_valid && i_tx_ready |-> o_tx.last == (tx_cnt == 3'h4))
    else $error("packet end flag misplaced");
  tx_spare_a: assert property (o_tx_valid && tx_cnt == 3'h0
    |-> o_tx.data[7] == 1'b0 && o_tx.data[3:1] == 3'h0)
    else $error("spare state bits not zero");
  rd_idle_a: assert property (!i_bus.rd |=> o_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // slp_codec_properties

bind slp_codec slp_codec_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_hang_sel(i_hang_sel), .i_rx_valid(i_rx_valid), .i_rx(i_rx), .o_tx(o_tx),
  .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
  .o_switch_output_first(o_switch_output_first),
  .o_switch_output_second(o_switch_output_second),
  .o_switch_output_third(o_switch_output_third));

// *** verification/slp_sink.sv ***
// model of the serial-side node that takes outgoing payload bytes
`timescale 1ns/1ps
module slp_sink
  import slp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire slp_pkg::slp_byte_t i_byte,
  output logic o_ready
);
  logic [1:0] ph; // stall phase, ready one cycle in four
  slp_byte_t got[$]; // bytes taken, oldest first

  // free-running phase for slow acceptance
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) ph <= 2'h0;
    else ph <= ph + 2'h1;
  end
  assign o_ready = !i_stall || ph == 2'h3;

  // collect every byte that moves
  always @(posedge i_sys_clk) begin
    if (i_rst_n && i_valid && o_ready) got.push_back(i_byte);
  end
endmodule // slp_sink

// *** verification/switch_logic_payload_codec_tb.sv ***
// self-checking bench for the payload codec
`timescale 1ns/1ps
module switch_logic_payload_codec_tb;
  import slp_pkg::*;
  localparam int TK = 10; // cycles per millisecond tick
  logic clk = 0, rst_n = 0, hang = 1, learn = 0, rxv = 0, stall = 0, rdy;
  logic [2:0] lin = 3'h0;
  logic [31:0] hdr = 32'h0, rdata;
  slp_bus_req_t bus = '0;
  slp_byte_t rx = '0, tx;
  logic txv, o1, o2, o3, lrn;
  int err_count = 0, tests_run = 0;
  always #2.5 clk = ~clk;

  slp_codec #(.TICK_CYCLES(TK), .BEACON_PERIOD_MS(30)) dut (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_bus(bus), .o_rdata(rdata), .i_logic_in(lin), .i_hang_sel(hang), .i_learn(learn),
    .i_rx_valid(rxv), .i_rx(rx), .i_rx_hdr_sn(hdr), .o_tx(tx), .o_tx_valid(txv),
    .i_tx_ready(rdy), .o_switch_output_first(o1), .o_switch_output_second(o2),
    .o_switch_output_third(o3), .o_learning(lrn));
  slp_sink sink (.i_sys_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_valid(txv),
    .i_byte(tx), .o_ready(rdy));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1; end
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) begin bus.addr <= a; bus.rd <= 1'b1; end
    @(posedge clk) bus.rd <= 1'b0;
    #1 check_val("rdata", exp, rdata);
  endtask
  // the idle gap the sender owes the previous packet, then one packet;
  // returns one cycle after the last byte so outputs are judged at once
  task automatic send_pkt(input logic [7:0] st, input logic [31:0] h, input bit ln,
                          input logic [31:0] sn);
    logic [39:0] b;
    b = {st, sn};
    repeat (15 * TK) @(posedge clk);
    for (int i = 0; i < (ln ? 5 : 1); i++) begin
      @(posedge clk) begin
        rxv <= 1'b1; hdr <= h; rx.data <= b[39 - 8 * i -: 8]; rx.last <= (i == (ln ? 4 : 0));
      end
    end
    @(posedge clk) rxv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic check_out(input logic [2:0] exp);
    check_val("outputs", {29'h0, exp}, {29'h0, o3, o2, o1});
  endtask
  // wait for one whole packet at the sink and judge it
  task automatic check_tx(input logic [7:0] st, input logic [31:0] sn);
    for (int k = 0; k < 600 && sink.got.size() < 5; k++) @(posedge clk);
    check_val("tx count", 32'h5, sink.got.size());
    if (sink.got.size() >= 5) begin
      for (int i = 0; i < 5; i++) begin
        check_val("tx byte", {23'h0, (i == 0 ? st : sn[31 - 8 * (i - 1) -: 8]), i == 4},
                  {23'h0, sink.got[i]});
      end
    end
    sink.got.delete();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    bus_rd(REG_CTRL, {29'h0, CTRL_RST});
    bus_rd(REG_OWN_SN, OWN_SN_RST);
    bus_rd(8'h10, 32'h0);
    bus_wr(REG_OWN_SN, 32'h1a2b3c4d);
    bus_rd(REG_OWN_SN, 32'h1a2b3c4d);
  endtask
  task automatic t_plain();
    send_pkt(8'h50, 32'h0badf00d, 0, 32'h0); check_out(3'h5);
    send_pkt(8'hff, 32'h0, 0, 32'h0); check_out(3'h7);
    send_pkt(8'h20, 32'h99, 1, 32'h77); check_out(3'h2);
    bus_rd(REG_STATUS, {24'h0, 8'h0} | 32'h302);
    send_pkt(8'h00, 32'h0, 0, 32'h0); check_out(3'h0);
    // short hang: held well inside 20 ms, gone just after it
    send_pkt(8'h40, 32'h0, 0, 32'h0); check_out(3'h4);
    repeat (17 * TK) @(posedge clk);
    check_out(3'h4);
    repeat (6 * TK) @(posedge clk);
    check_out(3'h0);
    // long hang with the select pin low
    hang <= 1'b0;
    send_pkt(8'h40, 32'h0, 0, 32'h0);
    repeat (480 * TK) @(posedge clk);
    check_out(3'h4);
    repeat (30 * TK) @(posedge clk);
    check_out(3'h0);
    hang <= 1'b1;
  endtask
  task automatic t_net();
    bus_wr(REG_CTRL, 32'h1);
    bus_wr(REG_FLUSH, 32'h0);
    send_pkt(8'h70, 32'h0000aaaa, 0, 32'h0); check_out(3'h0);
    learn <= 1'b1;
    repeat (8) @(posedge clk);
    check_val("learning", 32'h1, {31'h0, lrn});
    send_pkt(8'h00, 32'h0000aaaa, 1, 32'h0000bbbb);
    learn <= 1'b0;
    repeat (8) @(posedge clk);
    send_pkt(8'h20, 32'h0000aaaa, 0, 32'h0); check_out(3'h2);
    send_pkt(8'h70, 32'h0000bbbb, 0, 32'h0); check_out(3'h2);
    send_pkt(8'h40, 32'h0000cccc, 1, 32'h1a2b3c4d); check_out(3'h4);
    send_pkt(8'h30, 32'h0000cccc, 1, 32'h0000bbbb); check_out(3'h4);
    send_pkt(8'h00, 32'h0000aaaa, 0, 32'h0); check_out(3'h0);
  endtask
  task automatic t_fwd();
    bus_wr(REG_CTRL, 32'h2);
    stall <= 1'b1;
    send_pkt(8'h10, 32'h5566e7f8, 0, 32'h0);
    check_tx(8'h10, 32'h5566e7f8);
    stall <= 1'b0;
    bus_wr(REG_CTRL, 32'h3);
    bus_wr(REG_FLUSH, 32'h0);
    send_pkt(8'h10, 32'h00001234, 0, 32'h0);
    repeat (20) @(posedge clk);
    check_val("tx none", 32'h0, sink.got.size());
  endtask
  task automatic t_tx();
    bus_wr(REG_CTRL, 32'h0);
    lin <= 3'h6;
    check_tx(8'h60, 32'h1a2b3c4d);
    check_tx(8'h60, 32'h1a2b3c4d);
    lin <= 3'h0;
    repeat (40) @(posedge clk);
    sink.got.delete();
    repeat (25 * TK) @(posedge clk);
    check_val("tx idle", 32'h0, sink.got.size());
    bus_wr(REG_CTRL, 32'h4);
    check_tx(8'h11, 32'h1a2b3c4d);
    bus_wr(REG_CTRL, 32'h0);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_plain();
    t_net();
    t_fwd();
    t_tx();
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule // switch_logic_payload_codec_tb
